// >>> inc/tune_pkg.sv
// Constants shared by the fractional-N tuning control block.
`default_nettype none
package tune_pkg;
    // **********************************************************************
    // Register addresses on the write port
    // **********************************************************************
    localparam logic [4:0] ADDR_REF_RATIO = 5'h02;
    localparam logic [4:0] ADDR_INT_DIV   = 5'h03;
    localparam logic [4:0] ADDR_FRAC_DIV  = 5'h04;
    localparam logic [4:0] ADDR_FORWARD   = 5'h05;
    localparam logic [4:0] ADDR_MODE      = 5'h06;
    localparam logic [4:0] ADDR_PUMP      = 5'h09;
    localparam logic [4:0] ADDR_COMPARE   = 5'h0B;
    // **********************************************************************
    // Field positions
    // **********************************************************************
    localparam int MODE_MOD_EN_BIT  = 11;
    localparam int MODE_BYPASS_BIT  = 7;
    localparam int PUMP_DN_LSB      = 0;
    localparam int PUMP_UP_LSB      = 7;
    localparam int PUMP_OFS_LSB     = 14;
    localparam int PUMP_OFS_UP_BIT  = 21;
    localparam int PUMP_OFS_DN_BIT  = 22;
    localparam int GUARD_LSB        = 7;
    localparam int FWD_ADDR_LSB     = 3;
    localparam int FWD_DATA_LSB     = 7;
    localparam logic [3:0] SUB_OUT_DIV = 4'h2;
    localparam logic [3:0] SUB_DOUBLER = 4'h3;
    // **********************************************************************
    // Limits and reset values
    // **********************************************************************
    localparam logic [18:0] INT_MIN_INTEGER  = 19'h0_0010;
    localparam logic [18:0] INT_MIN_FRAC     = 19'h0_0014;
    localparam logic [18:0] INT_MAX_FRAC     = 19'h7_FFFC;
    localparam logic [5:0]  OUT_DIV_MAX      = 6'h3E;
    localparam logic [13:0] RST_REF_RATIO    = 14'h0001;
    localparam logic [18:0] RST_INT_DIV      = 19'h0_0038;
    localparam logic [23:0] RST_FRAC_DIV     = 24'h00_0000;
    localparam logic [11:0] RST_MODE         = 12'h080;
    localparam logic [22:0] RST_PUMP         = 23'h00_0000;
    localparam logic [1:0]  RST_GUARD        = 2'h0;
    localparam logic [5:0]  RST_OUT_DIV      = 6'h01;
    // **********************************************************************
    // Output scaling codes and phase-error thresholds of the guard
    // **********************************************************************
    typedef enum logic [1:0] {K_FUND = 2'b00, K_DOUBLE = 2'b01, K_DIVIDE = 2'b10} out_k_e;
    localparam logic [7:0] GUARD_TH1 = 8'h60;
    localparam logic [7:0] GUARD_TH2 = 8'h90;
    localparam logic [7:0] GUARD_TH3 = 8'hC0;
endpackage
`default_nettype wire

// >>> hw/tune_ctrl.sv
// Mode, divider, pump gain, offset and slip-guard control of a fractional-N synthesizer.
// Summary of operation
// - Slip guard boosts comparator gain while phase error exceeds the guard threshold.
// - Down gain sits in pump bits 6:0, up gain in bits 13:7.
// - Pump bit 21 adds offset to up pump, bit 22 to down pump.
// - Offset magnitude is pump bits 20:14, five microamps per step.
// - Oscillator stays in its fundamental band; band choice is calibrated automatically.
// - Subsystem register 2 bits 5:0 select even output divide 2 to 62.
// - Subsystem register 3 bit 0 set doubles the oscillator frequency.
// - Mode bit 11 clear and bit 7 set select integer mode.
// - Mode bit 11 set and bit 7 clear select fractional mode.
// - Integer mode accepts divide 16 up to 2^19-1 and ignores fraction.
// - Subsystem registers are written only through forwarding register 5.
// - Output frequency is oscillator over k: half, one, or the divider.
// - Fractional mode integer divide must lie from 20 to 524284.
// - Fraction is register 4 over two to the twenty-fourth.
// - Comparator rate is reference rate divided by register 2 ratio.
`timescale 1ns/100ps
`default_nettype none
module tune_ctrl
    import tune_pkg::*;
#(
    parameter int REF_W = 14
)
(
    input  wire logic              CLK,
    input  wire logic              RESETN,
    input  wire logic              WR_STROBE,
    input  wire logic [4:0]        WR_ADDR,
    input  wire logic [23:0]       WR_DATA,
    input  wire logic              REF_EDGE,
    input  wire logic [7:0]        PHASE_ERROR,
    output var  logic              PD_TICK,
    output var  logic              INT_MODE,
    output var  logic              FRAC_MODE,
    output var  logic [18:0]       N_INT,
    output var  logic [23:0]       N_FRAC,
    output var  logic              N_RANGE_ERROR,
    output var  logic [6:0]        PUMP_DOWN_GAIN,
    output var  logic [6:0]        PUMP_UP_GAIN,
    output var  logic [6:0]        OFFSET_MAG,
    output var  logic              OFFSET_UP_EN,
    output var  logic              OFFSET_DOWN_EN,
    output var  logic [1:0]        CYCLE_SLIP_GUARD,
    output var  logic              GAIN_BOOST,
    output var  logic [5:0]        OUT_DIV,
    output var  logic              DOUBLER_EN,
    output var  logic [1:0]        OUT_K
);
    import tune_pkg::*;

    // **********************************************************************
    // Parameter check
    // **********************************************************************
    // The reference counter and its reset value need a width from 1 to 14 bits.
    if (REF_W < 1 || REF_W > 14)
    begin : g_ref_w_check
        $error("REF_W must lie between 1 and 14.");
    end

    // **********************************************************************
    // Register file written by software
    // **********************************************************************
    // Writes are taken on any clock edge with the strobe high and land in staging
    // registers only. Apart from the reference ratio, which the comparator divider uses at
    // once, nothing reaches the outputs until the next comparator tick copies the set, so a half-written setting never steers the
    // dividers. Unmapped addresses are ignored, a reference ratio of zero is refused,
    // and the forwarding word carries the subsystem address in bits 6:3 and its
    // payload in bits 12:7. A refused word leaves the staged value as it was, so
    // software sees no sign of it on the outputs.
    logic [REF_W-1:0] ref_ratio_reg;
    logic [18:0]      int_div_reg;
    logic [23:0]      frac_div_reg;
    logic [11:0]      mode_reg;
    logic [22:0]      pump_reg;
    logic [1:0]       guard_reg;
    logic [5:0]       out_div_reg;
    logic             doubler_reg;

    // **********************************************************************
    // Helper functions
    // **********************************************************************
    // An output divider code is legal when it is 1 for the fundamental or an even
    // ratio from 2 up to the largest ratio; anything else would put an odd or
    // zero divide on the output path.
    function automatic logic div_code_ok(input logic [5:0] code);
        logic ok;
        ok = (code == 6'h01) || (!code[0] && (code != 6'h00) && (code <= OUT_DIV_MAX));
        return ok;
    endfunction

    // The integer ratio is checked against the limits of the selected mode; a mode
    // code that is neither integer nor fractional is always reported as an error.
    function automatic logic ratio_bad(input logic int_m, input logic frac_m, input logic [18:0] ratio);
        logic bad;
        bad = 1'b1;
        if (int_m)
        begin
            bad = (ratio < INT_MIN_INTEGER);
        end
        else if (frac_m)
        begin
            bad = (ratio < INT_MIN_FRAC) || (ratio > INT_MAX_FRAC);
        end
        return bad;
    endfunction

    // Address decode of the write port. Only one register is written per strobe,
    // since the addresses are distinct.
    wire wr_ref   = WR_STROBE && (WR_ADDR == ADDR_REF_RATIO);
    wire wr_int   = WR_STROBE && (WR_ADDR == ADDR_INT_DIV);
    wire wr_frac  = WR_STROBE && (WR_ADDR == ADDR_FRAC_DIV);
    wire wr_fwd   = WR_STROBE && (WR_ADDR == ADDR_FORWARD);
    wire wr_mode  = WR_STROBE && (WR_ADDR == ADDR_MODE);
    wire wr_pump  = WR_STROBE && (WR_ADDR == ADDR_PUMP);
    wire wr_guard = WR_STROBE && (WR_ADDR == ADDR_COMPARE);

    // Forwarded subsystem write: target register and payload.
    wire [3:0] fwd_addr = WR_DATA[FWD_ADDR_LSB +: 4];
    wire [5:0] fwd_data = WR_DATA[FWD_DATA_LSB +: 6];
    // Only even ratios up to 62, or 1 for the fundamental, are accepted.
    wire fwd_div_ok = div_code_ok(fwd_data);
    wire wr_sub_div = wr_fwd && (fwd_addr == SUB_OUT_DIV) && fwd_div_ok;
    wire wr_sub_dbl = wr_fwd && (fwd_addr == SUB_DOUBLER);
    // A ratio of zero would stall the comparator divider, so it is refused.
    wire ref_ok     = (WR_DATA[REF_W-1:0] != '0);

    // Software staging registers; main registers hold raw words. A word written
    // twice before a tick keeps only its last value.
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ref_ratio_reg <= REF_W'(RST_REF_RATIO);
            int_div_reg   <= RST_INT_DIV;
            frac_div_reg  <= RST_FRAC_DIV;
            mode_reg      <= RST_MODE;
            pump_reg      <= RST_PUMP;
            guard_reg     <= RST_GUARD;
        end
        else
        begin
            if (wr_ref && ref_ok)
                ref_ratio_reg <= WR_DATA[REF_W-1:0];
            if (wr_int)
                int_div_reg <= WR_DATA[18:0];
            if (wr_frac)
                frac_div_reg <= WR_DATA;
            if (wr_mode)
                mode_reg <= WR_DATA[11:0];
            if (wr_pump)
                pump_reg <= WR_DATA[22:0];
            if (wr_guard)
                guard_reg <= WR_DATA[GUARD_LSB +: 2];
        end
    end

    // Subsystem registers reachable only through the forwarding address. An
    // illegal divider code is dropped before this point, so the output path never
    // holds an odd or zero ratio even for one comparator period.
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            out_div_reg <= RST_OUT_DIV;
            doubler_reg <= 1'b0;
        end
        else
        begin
            if (wr_sub_div)
                out_div_reg <= fwd_data;
            if (wr_sub_dbl)
                doubler_reg <= fwd_data[0];
        end
    end

    // **********************************************************************
    // Comparator rate divider
    // **********************************************************************
    // The counter runs on reference edges only. The wrap test uses greater-or-equal
    // so that a ratio written below the present count ends the cycle at once
    // instead of letting the counter run round its whole range.
    logic [REF_W-1:0] ref_cnt_reg;
    logic [REF_W-1:0] ref_cnt_next;
    wire              ref_wrap = (ref_cnt_reg >= ref_ratio_reg - REF_W'(1));

    // One comparator tick per ratio reference edges.
    assign ref_cnt_next = ref_wrap ? '0 : ref_cnt_reg + REF_W'(1);

    // Counts reference edges and emits the comparator enable pulse.
    // The pulse is registered, so it trails its reference edge by one clock.
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ref_cnt_reg <= '0;
            PD_TICK     <= 1'b0;
        end
        else
        begin
            PD_TICK <= REF_EDGE && ref_wrap;
            if (REF_EDGE)
                ref_cnt_reg <= ref_cnt_next;
        end
    end

    // **********************************************************************
    // Decoding of the staged settings
    // **********************************************************************
    wire mod_en   = mode_reg[MODE_MOD_EN_BIT];
    wire mod_byp  = mode_reg[MODE_BYPASS_BIT];
    wire int_sel  = !mod_en && mod_byp;
    wire frac_sel = mod_en && !mod_byp;

    // Integer ratio limits differ by mode; other mode codes flag an error.
    wire range_err = ratio_bad(int_sel, frac_sel, int_div_reg);

    // Fraction counts only in fractional mode.
    wire [23:0] frac_eff = frac_sel ? frac_div_reg : 24'h00_0000;

    // Output scaling: doubler first, else divider, else fundamental. The doubler
    // wins over the divider so that enabling it alone is enough to move the output
    // above the fundamental band without first clearing the divider.
    wire [1:0] k_sel = doubler_reg ? K_DOUBLE :
                       (out_div_reg == 6'h01) ? K_FUND : K_DIVIDE;

    // **********************************************************************
    // Settings committed on the comparator tick
    // **********************************************************************
    // Every setting but the reference ratio switches on one comparator edge so the dividers never see a mix
    // of old and new values. The cost is latency: a write waits up to one full
    // comparator period, plus one clock, before it shows on the outputs. Reset
    // values match the staged reset words, so the first tick changes nothing
    // unless software has written in the meantime.
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            INT_MODE         <= 1'b1;
            FRAC_MODE        <= 1'b0;
            N_INT            <= RST_INT_DIV;
            N_FRAC           <= RST_FRAC_DIV;
            N_RANGE_ERROR    <= 1'b0;
            PUMP_DOWN_GAIN   <= 7'h00;
            PUMP_UP_GAIN     <= 7'h00;
            OFFSET_MAG       <= 7'h00;
            OFFSET_UP_EN     <= 1'b0;
            OFFSET_DOWN_EN   <= 1'b0;
            CYCLE_SLIP_GUARD <= RST_GUARD;
            OUT_DIV          <= RST_OUT_DIV;
            DOUBLER_EN       <= 1'b0;
            OUT_K            <= K_FUND;
        end
        else if (PD_TICK)
        begin
            INT_MODE         <= int_sel;
            FRAC_MODE        <= frac_sel;
            N_INT            <= int_div_reg;
            N_FRAC           <= frac_eff;
            N_RANGE_ERROR    <= range_err;
            PUMP_DOWN_GAIN   <= pump_reg[PUMP_DN_LSB +: 7];
            PUMP_UP_GAIN     <= pump_reg[PUMP_UP_LSB +: 7];
            OFFSET_MAG       <= pump_reg[PUMP_OFS_LSB +: 7];
            OFFSET_UP_EN     <= pump_reg[PUMP_OFS_UP_BIT];
            OFFSET_DOWN_EN   <= pump_reg[PUMP_OFS_DN_BIT];
            CYCLE_SLIP_GUARD <= guard_reg;
            OUT_DIV          <= out_div_reg;
            DOUBLER_EN       <= doubler_reg;
            OUT_K            <= k_sel;
        end
    end

    // **********************************************************************
    // Cycle-slip guard
    // **********************************************************************
    // Threshold chosen by the committed guard code; code zero turns the guard off.
    // The guard reads the committed code rather than the staged one, so a new
    // threshold starts at the same comparator edge as the gains it boosts.
    function automatic logic over_threshold(input logic [1:0] code, input logic [7:0] err);
        logic hit;
        hit = 1'b0;
        unique case (code)
            2'b00: hit = 1'b0;
            2'b01: hit = (err > GUARD_TH1);
            2'b10: hit = (err > GUARD_TH2);
            2'b11: hit = (err > GUARD_TH3);
        endcase
        return hit;
    endfunction

    wire boost_next = over_threshold(CYCLE_SLIP_GUARD, PHASE_ERROR);

    // Gain boost is momentary: it follows the error and drops once at or below threshold.
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            GAIN_BOOST <= 1'b0;
        else
            GAIN_BOOST <= boost_next;
    end

endmodule
`default_nettype wire

// >>> sim/tune_ctrl_asserts.sv
// Concurrent checks on the tuning control outputs.
`timescale 1ns/100ps
`default_nettype none
module tune_ctrl_asserts
    import tune_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        REF_EDGE,
    input wire logic [7:0]  PHASE_ERROR,
    input wire logic        PD_TICK,
    input wire logic        INT_MODE,
    input wire logic        FRAC_MODE,
    input wire logic [18:0] N_INT,
    input wire logic [23:0] N_FRAC,
    input wire logic        N_RANGE_ERROR,
    input wire logic [6:0]  PUMP_UP_GAIN,
    input wire logic [1:0]  CYCLE_SLIP_GUARD,
    input wire logic        GAIN_BOOST,
    input wire logic [5:0]  OUT_DIV,
    input wire logic        DOUBLER_EN,
    input wire logic [1:0]  OUT_K
);
    // Boost is due once the error passes the threshold of the guard code.
    function automatic logic over(input logic [7:0] e, input logic [1:0] g);
        over = (g == 2'h1) ? e > GUARD_TH1 : (g == 2'h2) ? e > GUARD_TH2 : (g == 2'h3) && e > GUARD_TH3;
    endfunction
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // A cycle with no comparator tick.
    sequence quiet;
        !PD_TICK;
    endsequence
    a_tick_from_ref: assert property (PD_TICK |-> $past(REF_EDGE))
        else $error("tick without reference edge");
    a_hold_no_tick: assert property (quiet |=> $stable({N_INT, N_FRAC, PUMP_UP_GAIN, CYCLE_SLIP_GUARD, OUT_DIV}))
        else $error("setting changed without tick");
    a_mode_onehot: assert property (!(INT_MODE && FRAC_MODE))
        else $error("both modes set");
    a_int_range: assert property (INT_MODE |-> N_RANGE_ERROR == (N_INT < INT_MIN_INTEGER))
        else $error("integer range flag wrong");
    a_frac_range: assert property (FRAC_MODE |-> N_RANGE_ERROR == (N_INT < INT_MIN_FRAC || N_INT > INT_MAX_FRAC))
        else $error("fractional range flag wrong");
    a_frac_zero: assert property (!FRAC_MODE |-> N_FRAC == 24'h00_0000)
        else $error("fraction outside fractional mode");
    a_div_even: assert property (OUT_DIV == 6'h01 || (!OUT_DIV[0] && OUT_DIV != 6'h00 && OUT_DIV <= OUT_DIV_MAX))
        else $error("illegal output divider");
    a_k_select: assert property (OUT_K == (DOUBLER_EN ? K_DOUBLE : OUT_DIV == 6'h01 ? K_FUND : K_DIVIDE))
        else $error("output scaling code wrong");
    a_boost_level: assert property ($past(RESETN, 2) |-> GAIN_BOOST == over($past(PHASE_ERROR), $past(CYCLE_SLIP_GUARD)))
        else $error("gain boost level wrong");
endmodule
bind tune_ctrl tune_ctrl_asserts u_tune_ctrl_asserts (.CLK(CLK), .RESETN(RESETN), .REF_EDGE(REF_EDGE),
    .PHASE_ERROR(PHASE_ERROR), .PD_TICK(PD_TICK), .INT_MODE(INT_MODE), .FRAC_MODE(FRAC_MODE), .N_INT(N_INT),
    .N_FRAC(N_FRAC), .N_RANGE_ERROR(N_RANGE_ERROR), .PUMP_UP_GAIN(PUMP_UP_GAIN), .GAIN_BOOST(GAIN_BOOST),
    .CYCLE_SLIP_GUARD(CYCLE_SLIP_GUARD), .OUT_DIV(OUT_DIV), .DOUBLER_EN(DOUBLER_EN), .OUT_K(OUT_K));
`default_nettype wire

// >>> sim/tune_ctrl_tb.sv
// Self-checking testbench of the tuning control block.
`timescale 1ns/100ps
`default_nettype none
module tune_ctrl_tb;
    import tune_pkg::*;
    // **********************************************************************
    // Stimulus, outputs and tables of expected results
    // **********************************************************************
    logic        clk = 1'b0, resetn = 1'b0, wr_strobe = 1'b0, ref_edge = 1'b0, t, int_mode, frac_mode, n_range_error;
    logic        pd_tick, offset_up_en, offset_down_en, gain_boost, doubler_en;
    logic [4:0]  wr_addr = 5'h00;
    logic [23:0] wr_data = 24'h00_0000, n_frac;
    logic [7:0]  phase_error = 8'h00, th;
    logic [18:0] n_int;
    logic [6:0]  pump_down_gain, pump_up_gain, offset_mag;
    logic [1:0]  guard, out_k;
    logic [5:0]  out_div;
    int          bad_count = 0, tests_run = 0, cycles = 0, i, n;
    logic [11:0] md [8] = '{12'h800, 12'h800, 12'h800, 12'h800, 12'h080, 12'h080, 12'h000, 12'h880};
    logic [18:0] nv [8] = '{19'h0_0013, 19'h0_0014, 19'h7_FFFC, 19'h7_FFFD,
                            19'h0_000F, 19'h0_0010, 19'h0_0038, 19'h0_0038};
    logic [2:0]  ex [8] = '{3'h3, 3'h2, 3'h2, 3'h3, 3'h5, 3'h4, 3'h1, 3'h1};
    logic [3:0]  fs [7] = '{4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h3, 4'h2};
    logic [5:0]  fv [7] = '{6'h02, 6'h03, 6'h3E, 6'h01, 6'h01, 6'h00, 6'h01};
    logic [8:0]  fe [7] = '{9'h012, 9'h012, 9'h1F2, 9'h1F5, 9'h1F5, 9'h1F2, 9'h008};

    tune_ctrl u_tune_ctrl (.CLK(clk), .RESETN(resetn), .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
        .REF_EDGE(ref_edge), .PHASE_ERROR(phase_error), .PD_TICK(pd_tick), .INT_MODE(int_mode),
        .FRAC_MODE(frac_mode), .N_INT(n_int), .N_FRAC(n_frac), .N_RANGE_ERROR(n_range_error),
        .PUMP_DOWN_GAIN(pump_down_gain), .PUMP_UP_GAIN(pump_up_gain), .OFFSET_MAG(offset_mag),
        .OFFSET_UP_EN(offset_up_en), .OFFSET_DOWN_EN(offset_down_en), .CYCLE_SLIP_GUARD(guard),
        .GAIN_BOOST(gain_boost), .OUT_DIV(out_div), .DOUBLER_EN(doubler_en), .OUT_K(out_k));

    // Clock, and a cycle ceiling far above the roughly 170 cycles the tests need.
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    // **********************************************************************
    // Access tasks and comparison
    // **********************************************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One write strobe, held for exactly one sampling edge.
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge clk);
        #1 wr_strobe = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(posedge clk);
        #1 wr_strobe = 1'b0;
    endtask
    // One reference edge; t keeps the tick seen in the following cycle.
    task automatic pulse();
        @(posedge clk);
        #1 ref_edge = 1'b1;
        @(posedge clk);
        #1 ref_edge = 1'b0;
        t = pd_tick;
        @(posedge clk);
        #1;
    endtask
    task automatic tick();
        pulse();
        chk("pd_tick", 24'h1, 24'(t)); // Tick follows the edge.
    endtask
    task automatic boost(input logic [7:0] e, input logic x);
        phase_error = e;
        @(posedge clk);
        #1 chk("gain_boost", 24'(gain_boost), 24'(x)); // Boost level.
    endtask

    // **********************************************************************
    // Test sequence
    // **********************************************************************
    initial
    begin
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        chk("mode", 24'h4, 24'({int_mode, frac_mode, n_range_error})); // Integer at reset.
        chk("out_k", 24'h0, 24'(out_k)); // Fundamental band.
        $display("test reset done");
        wr(ADDR_PUMP, 24'h20_00FF); // Integer mode: up enable, zero magnitude.
        wr(5'h07, 24'hFF_FFFF); // Unmapped address is ignored.
        chk("gains", 24'h0, 24'({pump_up_gain, pump_down_gain})); // Held until tick.
        tick(); // Commit.
        chk("gains", 24'h00FF, 24'({pump_up_gain, pump_down_gain})); // Gain fields.
        chk("offset", 24'h002, 24'({offset_mag, offset_up_en, offset_down_en})); // Up offset.
        wr(ADDR_MODE, 24'h00_0800); // Fractional mode before a down offset.
        wr(ADDR_PUMP, 24'h54_3232); // Down offset in fractional mode.
        tick(); // Commit.
        chk("mode", 24'h2, 24'({int_mode, frac_mode, n_range_error})); // Fractional.
        chk("gains", 24'h3232, 24'({pump_up_gain, pump_down_gain})); // Gain fields.
        chk("offset", 24'h141, 24'({offset_mag, offset_up_en, offset_down_en})); // Down offset.
        wr(ADDR_PUMP, 24'h4A_1919); // Gains and offset halved together.
        tick(); // Commit.
        chk("gains", 24'h1919, 24'({pump_up_gain, pump_down_gain})); // Gain fields.
        chk("offset", 24'h0A1, 24'({offset_mag, offset_up_en, offset_down_en})); // Scaled offset.
        $display("test pump done");
        wr(ADDR_FRAC_DIV, 24'h19_999A); // Fraction word.
        for (i = 0; i < 8; i++)
        begin
            wr(ADDR_MODE, {12'h000, md[i]}); // Mode code.
            wr(ADDR_INT_DIV, {5'h00, nv[i]}); // Integer ratio.
            tick(); // Commit.
            chk("n_int", {5'h00, nv[i]}, 24'(n_int)); // Integer ratio.
            chk("mode", 24'(ex[i]), 24'({int_mode, frac_mode, n_range_error})); // Mode, range.
            chk("n_frac", ex[i][1] ? 24'h19_999A : 24'h00_0000, n_frac); // Fraction.
        end
        $display("test mode done");
        for (i = 0; i < 7; i++)
        begin
            wr(ADDR_FORWARD, {11'h000, fv[i], fs[i], 3'h0}); // Forwarded write.
            tick(); // Commit.
            chk("out_sel", 24'({out_div, doubler_en, out_k}), 24'(fe[i])); // Forwarded.
        end
        $display("test forward done");
        for (i = 0; i < 4; i++)
        begin
            wr(ADDR_COMPARE, 24'(i) << 7); // Guard code.
            tick(); // Commit.
            chk("guard", 24'(i), 24'(guard)); // Guard field.
            th = (i == 1) ? GUARD_TH1 : (i == 2) ? GUARD_TH2 : (i == 3) ? GUARD_TH3 : 8'hFE;
            boost(th, 1'b0); // At threshold.
            boost(th + 8'h01, i != 0); // Above threshold.
        end
        phase_error = 8'h00;
        $display("test guard done");
        wr(ADDR_REF_RATIO, 24'h00_0003); // Ratio of three.
        wr(ADDR_REF_RATIO, 24'h00_0000); // Zero ratio is refused.
        pulse(); // Counter goes from zero to one.
        chk("pd_tick", 24'h0, 24'(t)); // No tick on the first edge of three.
        n = 0;
        for (i = 0; i < 6; i++)
        begin
            pulse(); // One reference edge.
            n += int'(t);
        end
        chk("ticks", 24'(n), 24'h2); // Every third edge.
        $display("test ratio done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
